/* File: pkg/tpmr_pkg.sv */
/*
   Constants, field positions and carrier types for the management register
   bank of the media (device 1) and coding (device 3) sublayers.
   Assumes one core clock and that the management bus pins are sampled there.
*/
// What this block does
// - Forced mode: role bit picks leader/follower
// - Four-bit PHY type field, reset 0010
// - Transmit-off bit suppresses transmit output
// - High-swing bit picks 2.4 V or 1.0 V
// - Energy-saving enable writable; ability reads zero
// - Media loopback returns transmit onto receive
// - Media status read-only with ability bits
// - Test mode 000 normal, 011 leader idle
// - Mode 001 alternates; 010 ten up, ten down
// - Eleven-bit frequency offset limit, resets eight
// - Sixteen-bit follower echo gain, resets 0x400
// - Reading link status releases latched-low bits
// - Link status holds live plus latched pairs
// - Error power value is read-only
// - Self-clearing soft reset shared by both sublayers
// - Coding loopback returns transmit onto receive
// - Coding power-down mirrors media power-down
// - Coding presence reads 10, powerdown ability one
// - Devices-in-package read 0x8b and 0xc000
// - Registers stay reachable during power-down
// - Latched-low bit reads zero after any drop
// - Forced settings apply only without negotiation
package tpmr_pkg;

   // Extended device addresses
   localparam logic [4:0] DEV_MEDIA = 5'h01;
   localparam logic [4:0] DEV_CODING = 5'h03;

   // Management frame opcodes and layout
   localparam logic [1:0] OP_ADDR = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ_INC = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
   localparam logic [5:0] PREAMBLE_MIN = 6'h20;
   localparam logic [4:0] IDX_HDR_LAST = 5'h0d;
   localparam logic [4:0] IDX_TA_DRIVE = 5'h0e;
   localparam logic [4:0] IDX_DATA_FIRST = 5'h10;
   localparam logic [4:0] IDX_LAST = 5'h1f;

   // Media sublayer offsets
   localparam logic [15:0] OFS_MEDIA_CTL_ONE = 16'h0000;
   localparam logic [15:0] OFS_SINGLE_PAIR_CTL = 16'h0834;
   localparam logic [15:0] OFS_LR_MEDIA_CTL = 16'h08f6;
   localparam logic [15:0] OFS_LR_MEDIA_STAT = 16'h08f7;
   localparam logic [15:0] OFS_TX_TEST_CTL = 16'h08f8;
   localparam logic [15:0] OFS_FREQ_OFS_THR = 16'h8015;
   localparam logic [15:0] OFS_ECHO_GAIN = 16'h81e7;
   localparam logic [15:0] OFS_LINK_STAT = 16'h8302;
   localparam logic [15:0] OFS_MSE = 16'h830b;
   // Coding sublayer offsets
   localparam logic [15:0] OFS_CODING_CTL_ONE = 16'h0000;
   localparam logic [15:0] OFS_CODING_STAT_ONE = 16'h0001;
   localparam logic [15:0] OFS_DEVS_LO = 16'h0005;
   localparam logic [15:0] OFS_DEVS_HI = 16'h0006;
   localparam logic [15:0] OFS_CODING_STAT_TWO = 16'h0008;
   localparam logic [15:0] OFS_LR_CODING_CTL = 16'h08e6;

   // Field positions
   localparam int B_SOFT_RESET = 15;
   localparam int B_LEADER = 14;
   localparam int B_TX_OFF = 14;
   localparam int B_CODING_LOOP = 14;
   localparam int B_HIGH_SWING = 12;
   localparam int B_POWERDOWN = 11;
   localparam int B_ENERGY = 10;
   localparam int B_MEDIA_LOOP = 0;
   localparam int B_PATTERN_LO = 13;

   // Fixed read values and reset values
   localparam logic [15:0] SP_CTL_FIXED = 16'h8000;
   localparam logic [15:0] LR_STAT_FIXED = 16'h2800;
   localparam int B_HS_ABLE = 12;
   localparam logic [15:0] CODING_STAT_ONE_VAL = 16'h0002;
   localparam logic [15:0] DEVS_LO_VAL = 16'h008b;
   localparam logic [15:0] DEVS_HI_VAL = 16'hc000;
   localparam logic [15:0] CODING_STAT_TWO_VAL = 16'h8000;
   localparam logic [3:0] PHY_TYPE_RST = 4'h2;
   localparam logic [10:0] FREQ_THR_RST = 11'h008;
   localparam logic [15:0] ECHO_GAIN_RST = 16'h0400;

   // Test patterns and symbol codes
   localparam logic [2:0] PAT_NORMAL = 3'h0;
   localparam logic [2:0] PAT_ALTERNATE = 3'h1;
   localparam logic [2:0] PAT_DROOP = 3'h2;
   localparam logic [2:0] PAT_IDLE_LEADER = 3'h3;
   localparam logic [4:0] DROOP_HALF = 5'h0a;
   localparam logic [4:0] DROOP_LEN = 5'h14;
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_POS = 2'h1;
   localparam logic [1:0] SYM_NEG = 2'h3;

   // Pin straps, caught during reset
   typedef struct packed {
      logic [4:0] phy_address;
      logic leader;
      logic high_swing;
      logic powerdown;
   } tpmr_strap_t;

   // Live conditions from the datapath
   typedef struct packed {
      logic far_receiver_ok;
      logic near_receiver_ok;
      logic descrambler_locked;
      logic link_good;
   } tpmr_live_t;

   // Settings that steer the datapath
   typedef struct packed {
      logic forced_mode;
      logic forced_leader_select;
      logic [3:0] single_pair_phy_type;
      logic high_swing_select;
      logic tx_output_off;
      logic energy_saving_enable;
      logic media_loopback_on;
      logic coding_loopback_on;
      logic powerdown;
      logic [2:0] tx_pattern_select;
      logic [10:0] freq_offset_limit;
      logic [15:0] follower_echo_gain;
   } tpmr_cfg_t;

   typedef enum logic {FR_PREAMBLE, FR_BODY} tpmr_frame_t;

endpackage

/* File: logic/tpmr_regs.sv */
/*
   Management register bank with its two-wire management slave (extended
   addressing), latched-low link status and transmitter test patterns.
   Assumes the management clock and data pins arrive asynchronously, and
   that live status, error power and the symbol tick come from core_clk.
*/
`timescale 1ns/1ns
module tpmr_regs (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   input wire tpmr_pkg::tpmr_strap_t strap,
   input wire logic negotiation_enable,
   input wire tpmr_pkg::tpmr_live_t live,
   input wire logic [15:0] error_power_value,
   input wire logic sym_tick,
   output tpmr_pkg::tpmr_cfg_t cfg,
   output logic soft_reset,
   output logic tx_drive_enable,
   output logic [1:0] test_sym,
   output logic test_sym_valid
);
   import tpmr_pkg::*;

   // Whole state of the block in one word
   typedef struct packed {
      logic [2:0] mdc_sync;     // Pin synchroniser, [0] first
      logic [2:0] mdio_sync;
      logic mdc_lvl;            // Filtered levels
      logic mdio_lvl;
      tpmr_frame_t frame;
      logic [5:0] pre_cnt;      // Ones seen in preamble
      logic [4:0] bit_idx;      // Bit position after preamble
      logic [11:0] hdr;         // Opcode, port, device
      logic hit;                // Frame is for us
      logic [15:0] shr;         // Incoming data
      logic [15:0] shout;       // Outgoing read data
      logic mdo;
      logic oe_n;
      logic [15:0] addr_media;
      logic [15:0] addr_coding;
      tpmr_strap_t strap;       // Straps caught in reset
      tpmr_cfg_t cfg;
      logic [3:0] ll;           // Latched-low copies
      logic soft_reset;
      logic tx_en;
      logic [4:0] sym_cnt;
      logic [1:0] sym;
      logic sym_act;
   } tpmr_state_t;

   tpmr_state_t st;
   tpmr_state_t next_st;
   tpmr_state_t rst_st;
   logic [3:0] live_vec;
   logic mdc_new;
   logic mdio_new;
   logic rise;
   logic [11:0] hdr_full;
   logic [15:0] wdata;
   logic [15:0] waddr;
   logic release_ll;

   assign live_vec = live;

   // Settings after reset or soft reset, straps included
   function automatic tpmr_cfg_t cfg_default(input tpmr_strap_t s);
      tpmr_cfg_t c;
      c = '0;
      c.forced_leader_select = s.leader;
      c.single_pair_phy_type = PHY_TYPE_RST;
      c.high_swing_select = s.high_swing;
      c.powerdown = s.powerdown;
      c.freq_offset_limit = FREQ_THR_RST;
      c.follower_echo_gain = ECHO_GAIN_RST;
      return c;
   endfunction

   // Read multiplexer; unmapped addresses read zero
   function automatic logic [15:0] rd_val(input logic [4:0] dev, input logic [15:0] a,
                                          input tpmr_state_t s, input logic [3:0] lv,
                                          input logic [15:0] mse);
      logic [15:0] v;
      v = '0;
      if (dev == DEV_MEDIA) begin
         unique case (a)
            OFS_MEDIA_CTL_ONE: v[B_POWERDOWN] = s.cfg.powerdown;
            OFS_SINGLE_PAIR_CTL: begin
               v = SP_CTL_FIXED;
               v[B_LEADER] = s.cfg.forced_leader_select;
               v[3:0] = s.cfg.single_pair_phy_type;
            end
            OFS_LR_MEDIA_CTL: begin
               v[B_TX_OFF] = s.cfg.tx_output_off;
               v[B_HIGH_SWING] = s.cfg.high_swing_select;
               v[B_ENERGY] = s.cfg.energy_saving_enable;
               v[B_MEDIA_LOOP] = s.cfg.media_loopback_on;
            end
            // Ability bits fixed, high swing from strap
            OFS_LR_MEDIA_STAT: begin
               v = LR_STAT_FIXED;
               v[B_HS_ABLE] = s.strap.high_swing;
            end
            OFS_TX_TEST_CTL: v[15:B_PATTERN_LO] = s.cfg.tx_pattern_select;
            OFS_FREQ_OFS_THR: v[10:0] = s.cfg.freq_offset_limit;
            OFS_ECHO_GAIN: v = s.cfg.follower_echo_gain;
            // Live and latched pairs
            OFS_LINK_STAT: v[9:0] = {s.ll[3], lv[3], s.ll[2], lv[2],
                                     s.ll[1], lv[1], 2'b00, s.ll[0], lv[0]};
            OFS_MSE: v = mse;
            OFS_DEVS_LO: v = DEVS_LO_VAL;
            OFS_DEVS_HI: v = DEVS_HI_VAL;
            default: v = '0;
         endcase
      end else begin
         unique case (a)
            OFS_CODING_CTL_ONE: begin
               v[B_CODING_LOOP] = s.cfg.coding_loopback_on;
               v[B_POWERDOWN] = s.cfg.powerdown;
            end
            OFS_CODING_STAT_ONE: v = CODING_STAT_ONE_VAL;
            OFS_DEVS_LO: v = DEVS_LO_VAL;
            OFS_DEVS_HI: v = DEVS_HI_VAL;
            OFS_CODING_STAT_TWO: v = CODING_STAT_TWO_VAL;
            default: v = '0;
         endcase
      end
      return v;
   endfunction

   // Reset image: straps caught while reset is held
   always_comb begin
      rst_st = '0;
      rst_st.frame = FR_PREAMBLE;
      rst_st.mdc_lvl = 1'b1;
      rst_st.mdio_lvl = 1'b1;
      rst_st.mdo = 1'b1;
      rst_st.oe_n = 1'b1;
      rst_st.strap = strap;
      rst_st.cfg = cfg_default(strap);
      rst_st.cfg.forced_mode = 1'b0;
   end

   // Next-state logic for the whole block
   always_comb begin
      next_st = st;
      release_ll = 1'b0;
      hdr_full = {st.hdr[10:0], st.mdio_lvl};
      wdata = {st.shr[14:0], st.mdio_lvl};
      waddr = (st.hdr[4:0] == DEV_MEDIA) ? st.addr_media : st.addr_coding;
      // Level changes count once second and third stage agree
      next_st.mdc_sync = {st.mdc_sync[1:0], mdc};
      next_st.mdio_sync = {st.mdio_sync[1:0], mdio_in};
      mdc_new = (st.mdc_sync[1] == st.mdc_sync[2]) ? st.mdc_sync[2] : st.mdc_lvl;
      mdio_new = (st.mdio_sync[1] == st.mdio_sync[2]) ? st.mdio_sync[2] : st.mdio_lvl;
      next_st.mdc_lvl = mdc_new;
      next_st.mdio_lvl = mdio_new;
      rise = mdc_new & ~st.mdc_lvl;
      hdr_full[0] = mdio_new;
      wdata[0] = mdio_new;
      next_st.soft_reset = 1'b0;
      // A drop clears the latched copy at once
      next_st.ll = st.ll & live_vec;
      // Forced settings only count without negotiation
      next_st.cfg.forced_mode = ~negotiation_enable;
      // Management frame, one bit per rising edge of mdc
      if (rise) begin
         unique case (st.frame)
            FR_PREAMBLE: begin
               if (mdio_new) begin
                  if (st.pre_cnt != 6'h3f) begin
                     next_st.pre_cnt = st.pre_cnt + 6'h01;
                  end
               end else begin
                  // First start bit after a full preamble
                  if (st.pre_cnt >= PREAMBLE_MIN) begin
                     next_st.frame = FR_BODY;
                     next_st.bit_idx = 5'h01;
                  end
                  next_st.pre_cnt = '0;
               end
            end
            FR_BODY: begin
               next_st.bit_idx = st.bit_idx + 5'h01;
               if (st.bit_idx == 5'h01 && mdio_new) begin
                  // Short-form frame: not ours, wait for preamble
                  next_st.frame = FR_PREAMBLE;
               end else if (st.bit_idx >= 5'h02 && st.bit_idx <= IDX_HDR_LAST) begin
                  next_st.hdr = hdr_full;
               end
               // Header complete: decide and fetch read data
               if (st.bit_idx == IDX_HDR_LAST) begin
                  next_st.hit = hdr_full[9:5] == st.strap.phy_address &&
                                (hdr_full[4:0] == DEV_MEDIA ||
                                 hdr_full[4:0] == DEV_CODING);
                  waddr = (hdr_full[4:0] == DEV_MEDIA) ? st.addr_media : st.addr_coding;
                  if (next_st.hit && hdr_full[11]) begin
                     // Reads answer in power-down as well
                     next_st.shout = rd_val(hdr_full[4:0], waddr, st,
                                            live_vec, error_power_value);
                     if (hdr_full[4:0] == DEV_MEDIA && waddr == OFS_LINK_STAT) begin
                        release_ll = 1'b1;
                        next_st.ll = live_vec;
                     end
                     if (hdr_full[11:10] == OP_READ_INC) begin
                        if (hdr_full[4:0] == DEV_MEDIA) begin
                           next_st.addr_media = st.addr_media + 16'h0001;
                        end else begin
                           next_st.addr_coding = st.addr_coding + 16'h0001;
                        end
                     end
                  end
               end
               // Second turnaround bit driven low on reads
               if (st.bit_idx == IDX_TA_DRIVE && st.hit && st.hdr[11]) begin
                  next_st.oe_n = 1'b0;
                  next_st.mdo = 1'b0;
               end
               if (st.bit_idx > IDX_TA_DRIVE && st.bit_idx < IDX_LAST && st.hit &&
                   st.hdr[11]) begin
                  next_st.mdo = st.shout[15];
                  next_st.shout = {st.shout[14:0], 1'b0};
               end
               if (st.bit_idx >= IDX_DATA_FIRST) begin
                  next_st.shr = wdata;
               end
               // End of frame: release pin, apply write or address
               if (st.bit_idx == IDX_LAST) begin
                  next_st.oe_n = 1'b1;
                  next_st.mdo = 1'b1;
                  next_st.frame = FR_PREAMBLE;
                  next_st.pre_cnt = '0;
                  if (st.hit && st.hdr[11:10] == OP_ADDR) begin
                     if (st.hdr[4:0] == DEV_MEDIA) begin
                        next_st.addr_media = wdata;
                     end else begin
                        next_st.addr_coding = wdata;
                     end
                  end else if (st.hit && st.hdr[11:10] == OP_WRITE) begin
                     if (st.hdr[4:0] == DEV_MEDIA) begin
                        unique case (waddr)
                           OFS_MEDIA_CTL_ONE: begin
                              next_st.soft_reset = wdata[B_SOFT_RESET];
                              next_st.cfg.powerdown = wdata[B_POWERDOWN];
                           end
                           OFS_SINGLE_PAIR_CTL: begin
                              next_st.cfg.forced_leader_select = wdata[B_LEADER];
                              next_st.cfg.single_pair_phy_type = wdata[3:0];
                           end
                           OFS_LR_MEDIA_CTL: begin
                              next_st.cfg.tx_output_off = wdata[B_TX_OFF];
                              next_st.cfg.high_swing_select = wdata[B_HIGH_SWING];
                              next_st.cfg.energy_saving_enable = wdata[B_ENERGY];
                              next_st.cfg.media_loopback_on = wdata[B_MEDIA_LOOP];
                           end
                           OFS_TX_TEST_CTL: begin
                              next_st.cfg.tx_pattern_select = wdata[15:B_PATTERN_LO];
                           end
                           OFS_FREQ_OFS_THR: next_st.cfg.freq_offset_limit = wdata[10:0];
                           OFS_ECHO_GAIN: next_st.cfg.follower_echo_gain = wdata;
                           // Read-only or unmapped: write ignored, forced_mode still tracks
                           default: next_st.soft_reset = 1'b0;
                        endcase
                     end else if (waddr == OFS_CODING_CTL_ONE) begin
                        // Same soft reset and power-down as the media side
                        next_st.soft_reset = wdata[B_SOFT_RESET];
                        next_st.cfg.coding_loopback_on = wdata[B_CODING_LOOP];
                        next_st.cfg.powerdown = wdata[B_POWERDOWN];
                     end
                  end
               end
            end
         endcase
      end
      // Soft reset restores settings one cycle after the write
      if (st.soft_reset) begin
         next_st.cfg = cfg_default(st.strap);
         next_st.cfg.forced_mode = ~negotiation_enable;
      end
      // Transmit output gated by transmit-off and power-down
      next_st.tx_en = ~st.cfg.tx_output_off & ~st.cfg.powerdown;
      // Test symbols, one per symbol tick
      if (sym_tick) begin
         unique case (st.cfg.tx_pattern_select)
            PAT_ALTERNATE: begin
               next_st.sym = (st.sym == SYM_POS) ? SYM_NEG : SYM_POS;
               next_st.sym_act = 1'b1;
               next_st.sym_cnt = '0;
            end
            PAT_DROOP: begin
               next_st.sym = (st.sym_cnt < DROOP_HALF) ? SYM_POS : SYM_NEG;
               next_st.sym_act = 1'b1;
               next_st.sym_cnt = (st.sym_cnt == DROOP_LEN - 5'h01) ? '0 :
                                 st.sym_cnt + 5'h01;
            end
            default: begin
               // Normal and idle-leader modes use the datapath
               next_st.sym = SYM_ZERO;
               next_st.sym_act = 1'b0;
               next_st.sym_cnt = '0;
            end
         endcase
      end
   end

   // Single state register, frozen while ce is low
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= rst_st;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign mdio_out = st.mdo;
   assign mdio_oe_n = st.oe_n;
   assign cfg = st.cfg;
   assign soft_reset = st.soft_reset;
   assign tx_drive_enable = st.tx_en;
   assign test_sym = st.sym;
   assign test_sym_valid = st.sym_act;

   // Checks next to the logic
   property p_reset_type;
      @(posedge core_clk) disable iff (!resetn)
      ($rose(resetn) && $past(ce)) |-> cfg.single_pair_phy_type == 4'h2 &&
                                        cfg.freq_offset_limit == 11'h008 &&
                                        cfg.follower_echo_gain == 16'h0400;
   endproperty
   a_reset_type: assert property (p_reset_type) else $error("bad reset values");

   property p_tx_off;
      @(posedge core_clk) disable iff (!resetn)
      (cfg.tx_output_off && ce) |=> !tx_drive_enable;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("tx not suppressed");

   property p_ll_drop;
      @(posedge core_clk) disable iff (!resetn)
      (!live.link_good && ce) |=> !st.ll[0];
   endproperty
   a_ll_drop: assert property (p_ll_drop) else $error("latched bit kept");

   property p_release;
      @(posedge core_clk) disable iff (!resetn)
      (release_ll && ce) |=> st.ll == $past(live_vec);
   endproperty
   a_release: assert property (p_release) else $error("release not reloaded");

   property p_srst_pulse;
      @(posedge core_clk) disable iff (!resetn)
      (soft_reset && ce) |=> !soft_reset && cfg.single_pair_phy_type == 4'h2;
   endproperty
   a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset stuck");

   property p_forced;
      @(posedge core_clk) disable iff (!resetn)
      (negotiation_enable && ce) |=> !cfg.forced_mode;
   endproperty
   a_forced: assert property (p_forced) else $error("forced while negotiating");

   property p_droop_len;
      @(posedge core_clk) disable iff (!resetn)
      st.sym_cnt < 5'd20;
   endproperty
   a_droop_len: assert property (p_droop_len) else $error("droop count overrun");

   property p_alternate;
      @(posedge core_clk) disable iff (!resetn)
      (sym_tick && ce && test_sym_valid && cfg.tx_pattern_select == 3'h1)
         |=> test_sym != $past(test_sym);
   endproperty
   a_alternate: assert property (p_alternate) else $error("no alternation");

   property p_normal;
      @(posedge core_clk) disable iff (!resetn)
      (sym_tick && ce && cfg.tx_pattern_select == 3'h0) |=> !test_sym_valid;
   endproperty
   a_normal: assert property (p_normal) else $error("pattern in normal mode");

   property p_drive_in_frame;
      @(posedge core_clk) disable iff (!resetn)
      !mdio_oe_n |-> st.frame == FR_BODY && st.hit && st.hdr[11];
   endproperty
   a_drive_in_frame: assert property (p_drive_in_frame) else $error("stray drive");

   c_read: cover property (@(posedge core_clk) disable iff (!resetn) $fell(mdio_oe_n));
   c_write: cover property (@(posedge core_clk) disable iff (!resetn) $rose(soft_reset));
   c_release: cover property (@(posedge core_clk) disable iff (!resetn) release_ll);
   c_droop: cover property (@(posedge core_clk) disable iff (!resetn)
                            st.sym_cnt == 5'd19);

endmodule

/* File: tb/tpmr_host.sv */
/* Management host model driving whole frames.
   Assumes mdc half period of six core clocks and a pull-up on the wire. */
`timescale 1ns/1ns
module tpmr_host (
   input wire logic core_clk,
   input wire logic mdio_out,
   input wire logic mdio_oe_n,
   output logic mdc,
   output logic mdio_in
);
   logic host_bit = 1'b1; // Released wire floats high
   initial mdc = 1'b0;
   // Device owns the wire while its enable is low
   assign mdio_in = mdio_oe_n ? host_bit : mdio_out;
   // One frame with a fresh preamble
   task automatic xfer(input logic [1:0] op, input logic [4:0] dv, input logic [15:0] d,
      output logic [15:0] q);
      logic [63:0] f;
      f = {32'hffffffff, 2'b00, op, 5'h05, dv, 2'b10, d};
      for (int i = 63; i >= 0; i--) begin
         host_bit = (op[1] && i < 18) ? 1'b1 : f[i]; // Let go for read data
         mdc = 1'b0;
         repeat (6) @(negedge core_clk);
         if (i < 16) q = {q[14:0], mdio_in};
         mdc = 1'b1;
         repeat (6) @(negedge core_clk);
      end
   endtask
endmodule

/* File: tb/tb.sv */
/* Bench for the register bank, host model on the management pins.
   Assumes port address 5 strapped, leader and high swing straps set. */
`timescale 1ns/1ns
module tb;
   import tpmr_pkg::*;
   logic core_clk = 0, resetn = 0, sym_tick = 0, neg_en = 1, mdc, mdio_in, mdio_out, mdio_oe_n;
   logic soft_reset, tx_drive_enable, test_sym_valid;
   logic [1:0] test_sym, p;
   logic [15:0] mse = 0, q, d;
   tpmr_strap_t strap = '{5'h05, 1'b1, 1'b1, 1'b0};
   tpmr_live_t live = '1;
   tpmr_cfg_t cfg;
   int num_errors = 0, num_checks = 0, seed = 32'hfb888656;
   tpmr_regs i_dut (.core_clk, .resetn, .ce(1'b1), .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
      .strap, .negotiation_enable(neg_en), .live, .error_power_value(mse), .sym_tick, .cfg,
      .soft_reset, .tx_drive_enable, .test_sym, .test_sym_valid);
   tpmr_host i_host (.core_clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);
   initial forever #20 core_clk = ~core_clk;
   // Symbol tick every other cycle
   always @(negedge core_clk) sym_tick <= ~sym_tick;
   task automatic chk(input logic [15:0] g, e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [4:0] dv, input logic [15:0] a, v);
      i_host.xfer(OP_ADDR, dv, a, q);
      i_host.xfer(OP_WRITE, dv, v, q);
   endtask
   task automatic rc(input logic [4:0] dv, input logic [15:0] a, e);
      i_host.xfer(OP_ADDR, dv, a, q);
      i_host.xfer(OP_READ, dv, 16'h0, q);
      chk(q, e);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, well past the expected run
   initial begin
      repeat (70000) @(posedge core_clk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (8) @(negedge core_clk);
      resetn = 1;
      rc(DEV_MEDIA, OFS_SINGLE_PAIR_CTL, 16'hc002);
      rc(DEV_MEDIA, OFS_LR_MEDIA_CTL, 16'h1000);
      rc(DEV_MEDIA, OFS_LR_MEDIA_STAT, 16'h3800);
      rc(DEV_MEDIA, OFS_TX_TEST_CTL, 16'h0);
      rc(DEV_CODING, OFS_CODING_STAT_ONE, 16'h2);
      rc(DEV_CODING, OFS_CODING_STAT_TWO, 16'h8000);
      rc(DEV_CODING, OFS_DEVS_LO, 16'h8b);
      rc(DEV_CODING, OFS_DEVS_HI, 16'hc000);
      $display("reset map done");
      rc(DEV_MEDIA, OFS_LINK_STAT, 16'h0151);
      rc(DEV_MEDIA, OFS_LINK_STAT, 16'h03f3);
      live.link_good = 0;
      @(negedge core_clk) live.link_good = 1;
      rc(DEV_MEDIA, OFS_LINK_STAT, 16'h03f1);
      rc(DEV_MEDIA, OFS_LINK_STAT, 16'h03f3);
      $display("latch test done");
      mse = 16'($random(seed));
      d = 16'($random(seed));
      wr(DEV_MEDIA, OFS_MSE, ~mse);
      rc(DEV_MEDIA, OFS_MSE, mse);
      wr(DEV_MEDIA, OFS_ECHO_GAIN, d);
      rc(DEV_MEDIA, OFS_ECHO_GAIN, d);
      wr(DEV_MEDIA, OFS_FREQ_OFS_THR, d);
      rc(DEV_MEDIA, OFS_FREQ_OFS_THR, d & 16'h07ff);
      wr(DEV_MEDIA, OFS_SINGLE_PAIR_CTL, d);
      rc(DEV_MEDIA, OFS_SINGLE_PAIR_CTL, 16'h8000 | (d & 16'h400f));
      wr(DEV_MEDIA, OFS_LR_MEDIA_STAT, d);
      rc(DEV_MEDIA, OFS_LR_MEDIA_STAT, 16'h3800);
      wr(DEV_CODING, OFS_CODING_CTL_ONE, 16'h4800);
      rc(DEV_MEDIA, OFS_MEDIA_CTL_ONE, 16'h0800);
      rc(DEV_CODING, OFS_CODING_CTL_ONE, 16'h4800);
      chk({15'h0, tx_drive_enable}, 16'h0);
      neg_en = d[0];
      wr(DEV_MEDIA, OFS_MEDIA_CTL_ONE, 16'h0);
      wr(DEV_MEDIA, OFS_LR_MEDIA_CTL, 16'h4401);
      chk({cfg.tx_output_off, cfg.energy_saving_enable, cfg.media_loopback_on,
         tx_drive_enable, cfg.forced_mode}, {4'he, ~d[0]});
      $display("write test done");
      // Opposite symbol half a period later, both patterns
      for (int m = 1; m <= 2; m++) begin
         wr(DEV_MEDIA, OFS_TX_TEST_CTL, 16'(m) << 13);
         repeat (4) begin
            p = test_sym;
            repeat (m == 1 ? 2 : 20) @(negedge core_clk);
            chk({test_sym_valid, test_sym}, {1'b1, p ^ 2'h2});
         end
      end
      wr(DEV_MEDIA, OFS_TX_TEST_CTL, 16'h6000);
      chk({15'h0, test_sym_valid}, 16'h0);
      wr(DEV_CODING, OFS_CODING_CTL_ONE, 16'h8000);
      rc(DEV_MEDIA, OFS_ECHO_GAIN, 16'h0400);
      rc(DEV_CODING, OFS_CODING_CTL_ONE, 16'h0);
      $display("pattern and reset test done");
      end_sim();
   end
endmodule
